//--- bench/lec_line_model.sv
// Purpose: line-side stand-in driving slot, level, mark, pattern and event strobes
// Assumes: the block synchronises every pin, so each strobe lasts several clocks
// Notes:   pins change only right after a rising edge
`default_nettype none

module lec_line_model (
  // clock
  input  wire logic       pclk,
  // line strobes and level
  output logic            tx_slot_pin,
  output logic            tx_above_pin,
  output logic            tx_mark_pin,
  output logic            prbs_slot_pin,
  output logic      [4:0] error_event_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] pin_q;

  initial begin
    pin_q        = 8'h00;
    tx_above_pin = 1'b0;
  end

  assign tx_slot_pin      = pin_q[0];
  assign tx_mark_pin      = pin_q[1];
  assign prbs_slot_pin    = pin_q[2];
  assign error_event_pins = pin_q[7:3];

  ////////////////////////////////////////////////////////////////////////////
  // high long enough for the synchroniser, low long enough to see a new edge
  task automatic strobe(input int b);
    @(posedge pclk);
    pin_q[b] <= 1'b1;
    repeat (2) @(posedge pclk);
    pin_q[b] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : strobe

  // level settles one clock before the slot edge that samples it
  task automatic slot(input logic above);
    @(posedge pclk);
    tx_above_pin <= above;
    strobe(0);
  endtask : slot

endmodule : lec_line_model

`default_nettype wire

//--- bench/lec_top_tb.sv
// Purpose: self-checking bench for lec_top
// Assumes: zero-wait APB slave; line model drives all pins
// Notes:   reads are scored by a monitor against a queue of expectations
`default_nettype none

module lec_top_tb
  import lec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int UPD = 50;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_slot_pin;
  logic        tx_above_pin;
  logic        tx_mark_pin;
  logic        prbs_slot_pin;
  logic [4:0]  error_event_pins;
  logic        tx_loss_flag;
  logic [10:0] tx_threshold_mv;
  logic [11:0] rx_threshold_mv;
  logic        zero_run_definition;
  logic        viol_pulse;
  logic        ins_pulse;
  logic        irq;
  logic        slv_q;
  logic [7:0]  ctl;
  logic [31:0] exp_q[$];
  int          err_count;
  int          cmp_count;
  int          viol_n;
  int          ins_n;
  int          cyc;
  int          n;
  int          t0;
  int          e;
  int          k[5];
  logic [10:0] tx_tab [8] = '{11'h4B0, 11'h384, 11'h258, 11'h190, 11'h262, 11'h1E0, 11'h140, 11'h0F0};
  logic [11:0] rx_tab [4] = '{12'h3E8, 12'h578, 12'h708, 12'h898};

  lec_top #(.UPD_CYCLES(UPD)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_slot_pin(tx_slot_pin), .tx_above_pin(tx_above_pin), .tx_mark_pin(tx_mark_pin),
    .prbs_slot_pin(prbs_slot_pin), .error_event_pins(error_event_pins),
    .tx_loss_flag(tx_loss_flag), .tx_threshold_mv(tx_threshold_mv), .rx_threshold_mv(rx_threshold_mv),
    .zero_run_definition(zero_run_definition), .violation_insert_pulse(viol_pulse),
    .error_insert_pulse(ins_pulse), .irq(irq));

  lec_line_model line_u (
    .pclk(pclk), .tx_slot_pin(tx_slot_pin), .tx_above_pin(tx_above_pin), .tx_mark_pin(tx_mark_pin),
    .prbs_slot_pin(prbs_slot_pin), .error_event_pins(error_event_pins));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] gv, input logic [31:0] ev);
    cmp_count++;
    if (gv !== ev) begin
      err_count++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, ev, gv);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    slv_q = pslverr;
    if (pready !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, 1'b1, pready);
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ev);
    exp_q.push_back(ev);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_n(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : wait_n

  task automatic wait_irq();
    int i;
    i = 0;
    #1;
    while (irq !== 1'b1 && i < 200) begin
      @(posedge pclk);
      #1;
      i++;
    end
    if (irq !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, 1'b1, irq);
      report_and_stop();
    end
  endtask : wait_irq

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // read data is valid in the access cycle, so score it at that edge
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (viol_pulse === 1'b1) viol_n++;
    if (ins_pulse === 1'b1) ins_n++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      check(prdata, exp_q.pop_front());
    end
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    void'($urandom(73979));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_n(1);
    check(32'(tx_threshold_mv), 32'h384);
    rd(LOS_CFG_OFF, 32'h15);
    rd(ERR_CTL_OFF, 32'h0);
    rd(CNT_LOW_OFF, 32'h0);
    rd(12'h01C, 32'h0);
    check(32'(slv_q), 32'h1);
    done("reset");
    for (int s = 0; s < 2; s++) begin
      wr(LINE_CFG_OFF, 32'(s * 2 + 1));
      for (int c = 0; c < 4; c++) begin
        wr(LOS_CFG_OFF, 32'(c * 20 + 1));
        wait_n(2);
        check(32'(tx_threshold_mv), 32'(tx_tab[s * 4 + c]));
        check(32'(rx_threshold_mv), 32'(rx_tab[c]));
        rd(LOS_CFG_OFF, 32'(c * 20 + 1));
      end
    end
    wr(LINE_CFG_OFF, 32'h0);
    wait_n(2);
    check(32'(rx_threshold_mv), 32'h4B0);
    done("thresholds");
    wr(INT_MSK_OFF, 32'h1);
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 16 : (c == 1) ? 32 : 64;
      wr(LOS_CFG_OFF, 32'(8'h14 + c));
      line_u.slot(1'b1);
      repeat (n - 1) line_u.slot(1'b0);
      check(32'(tx_loss_flag), 32'h0);
      line_u.slot(1'b0);
      wait_n(1);
      check(32'(tx_loss_flag), 32'h1);
      check(32'(irq), 32'h1);
      wr(INT_STS_OFF, 32'h1);
      wait_n(2);
      check(32'(irq), 32'h0);
      line_u.slot(1'b1);
      wait_n(1);
      check(32'(tx_loss_flag), 32'h0);
      rd(INT_STS_OFF, 32'h2);
      wr(INT_STS_OFF, 32'h3);
    end
    done("loss");
    // second strobe of each kind must not insert again
    for (int b = 0; b < 2; b++) begin
      wr(ERR_CTL_OFF, 32'(8'h40 >> b));
      rd(ERR_CTL_OFF, 32'(8'h40 >> b));
      repeat (2) line_u.strobe(b + 1);
      rd(ERR_CTL_OFF, 32'h0);
    end
    check(32'(viol_n), 32'h1);
    check(32'(ins_n), 32'h1);
    done("insert");
    for (int sel = 0; sel < 8; sel++) begin
      ctl = {sel[0], 2'b00, sel[2:0], 2'b00};
      wr(ERR_CTL_OFF, 32'(ctl));
      for (int i = 0; i < 5; i++) begin
        k[i] = $urandom_range(3, 1);
        repeat (k[i]) line_u.strobe(3 + i);
      end
      e = ((sel == 1 || sel == 3) ? k[0] : 0) + ((sel == 2 || sel == 3) ? k[1] : 0)
        + ((sel == 4 || sel == 6) ? k[2] : 0) + ((sel == 5 || sel == 6) ? k[3] : 0) + ((sel == 7) ? k[4] : 0);
      wr(ERR_CTL_OFF, 32'(ctl | 8'h01));
      wait_n(3);
      check(32'(zero_run_definition), 32'(sel[0]));
      rd(CNT_HIGH_OFF, 32'(e[15:8]));
      rd(CNT_LOW_OFF, 32'(e[7:0]));
      rd(INT_STS_OFF, 32'h4);
      wr(INT_STS_OFF, 32'h4);
    end
    repeat (2) line_u.strobe(7);
    wr(ERR_CTL_OFF, 32'h9D);
    wait_n(3);
    rd(CNT_LOW_OFF, 32'(k[4]));
    wr(ERR_CTL_OFF, 32'h9C);
    wr(ERR_CTL_OFF, 32'h9D);
    wait_n(3);
    rd(CNT_LOW_OFF, 32'h2);
    done("counting");
    wr(INT_STS_OFF, 32'h7);
    wr(INT_MSK_OFF, 32'h4);
    wr(ERR_CTL_OFF, 32'h06);
    wait_irq();
    t0 = cyc;
    wr(INT_STS_OFF, 32'h4);
    wait_n(2);
    wait_irq();
    check(32'(cyc - t0), 32'(UPD));
    wr(ERR_CTL_OFF, 32'h04);
    wr(INT_STS_OFF, 32'h4);
    wait_n(3 * UPD);
    check(32'(irq), 32'h0);
    done("auto");
    report_and_stop();
  end

endmodule : lec_top_tb

`default_nettype wire

//--- hdl/lec_cnt_if.sv
// Purpose: carries counter control and results between the register bank and the counter
// Assumes: single clock domain
// Notes:   events are one-cycle pulses
`default_nettype none

interface lec_cnt_if;
  import lec_pkg::*;
  logic [2:0]            sel;
  logic                  auto_mode;
  logic                  manual_req;
  logic [NUM_EVENTS-1:0] events;
  logic [CNT_W-1:0]      count;
  logic                  updated;

  modport ctrl (output sel, output auto_mode, output manual_req, output events,
                input count, input updated);
  modport cnt  (input sel, input auto_mode, input manual_req, input events,
                output count, output updated);
endinterface : lec_cnt_if

`default_nettype wire

//--- hdl/lec_err_counter.sv
// Purpose: accumulates selected error events and snapshots them on update
// Assumes: events are single-cycle pulses on pclk
// Notes:   accumulator saturates instead of wrapping
`default_nettype none

module lec_err_counter
  import lec_pkg::*;
#(
  parameter int UPD_CYCLES = UPDATE_CYCLES
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control and results
  lec_cnt_if.cnt    c
);

  localparam int TW = $clog2(UPD_CYCLES + 1);

  logic [TW-1:0]    tmr_q,   tmr_d;
  logic [CNT_W-1:0] acc_q,   acc_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic             upd_q;
  logic             tick;
  logic             update;
  logic             hit;

  function automatic logic event_hit(input logic [2:0] sel, input logic [NUM_EVENTS-1:0] ev);
    unique case (sel)
      3'h0: event_hit = 1'b0;
      3'h1: event_hit = ev[0];
      3'h2: event_hit = ev[1];
      3'h3: event_hit = ev[0] | ev[1];
      3'h4: event_hit = ev[2];
      3'h5: event_hit = ev[3];
      3'h6: event_hit = ev[2] | ev[3];
      3'h7: event_hit = ev[4];
    endcase
  endfunction : event_hit

  always_comb begin
    tick    = c.auto_mode && (tmr_q == TW'(UPD_CYCLES - 1));                    // R9
    update  = tick || (c.manual_req && !c.auto_mode);                           // R9 R10
    hit     = event_hit(c.sel, c.events);                                       // R8
    tmr_d   = (!c.auto_mode || tick) ? '0 : tmr_q + TW'(1);
    count_d = update ? acc_q : count_q;                                         // R10
    if (update) begin
      acc_d = {{(CNT_W-1){1'b0}}, hit};                                         // R12
    end else if (hit && !(&acc_q)) begin
      acc_d = acc_q + CNT_W'(1);
    end else begin
      acc_d = acc_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q   <= '0;
      acc_q   <= '0;
      count_q <= '0;
      upd_q   <= 1'b0;
    end else begin
      tmr_q   <= tmr_d;
      acc_q   <= acc_d;
      count_q <= count_d;
      upd_q   <= update;
    end
  end

  assign c.count   = count_q;
  assign c.updated = upd_q;

  a_manual_update: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (c.manual_req && !c.auto_mode) |=> (upd_q && count_q == $past(acc_q)))
    else $error("manual request did not snapshot the accumulator");
  a_auto_update: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (c.auto_mode && tmr_q == TW'(UPD_CYCLES - 1)) |=> upd_q)
    else $error("automatic update missed its second");
  a_acc_restart: assert property (@(posedge pclk) disable iff (!presetn) // R12
    upd_q |-> acc_q <= CNT_W'(1))
    else $error("accumulator not restarted on update");
  a_count_disabled: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (c.sel == 3'h0 && !update) |=> acc_q == $past(acc_q))
    else $error("accumulator moved while counting disabled");

endmodule : lec_err_counter

`default_nettype wire

//--- hdl/lec_pkg.sv
// Purpose: shared constants for the loss and error count control block
// Assumes: 32-bit APB, one aligned word per register, 8-bit data in the low bits
// Notes:   thresholds are given in millivolts (peak for transmit, peak-to-peak for receive)
`default_nettype none

package lec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] LOS_CFG_OFF  = 12'h000;
  localparam logic [11:0] ERR_CTL_OFF  = 12'h004;
  localparam logic [11:0] CNT_HIGH_OFF = 12'h008;
  localparam logic [11:0] CNT_LOW_OFF  = 12'h00C;
  localparam logic [11:0] INT_STS_OFF  = 12'h010;
  localparam logic [11:0] INT_MSK_OFF  = 12'h014;
  localparam logic [11:0] LINE_CFG_OFF = 12'h018;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] LOS_CFG_RST  = 8'h15;
  localparam logic [7:0] ERR_CTL_RST  = 8'h00;
  localparam logic [1:0] LINE_CFG_RST = 2'h0;
  localparam logic [2:0] INT_MSK_RST  = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ZERO_DEF_BIT    = 7;
  localparam int VIOL_INS_BIT    = 6;
  localparam int ERR_INS_BIT     = 5;
  localparam int COUNT_EVENT_SELECT_LSB     = 2;
  localparam int CNT_MODE_BIT    = 1;
  localparam int CNT_REQ_BIT     = 0;
  localparam int RX_THR_LSB      = 4;
  localparam int TX_THR_LSB      = 2;
  localparam int TX_PER_LSB      = 0;
  localparam int MONITOR_BIT     = 0;
  localparam int SINGLE_END_BIT  = 1;
  localparam int IRQ_DECLARE_BIT = 0;
  localparam int IRQ_CLEAR_BIT   = 1;
  localparam int IRQ_UPDATE_BIT  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // loss periods in pulses and threshold tables
  localparam logic [6:0] PERIOD_SHORT = 7'h10;
  localparam logic [6:0] PERIOD_MID   = 7'h20;
  localparam logic [6:0] PERIOD_LONG  = 7'h40;
  localparam logic [10:0] TX_DIFF_MV [4] = '{11'h4B0, 11'h384, 11'h258, 11'h190};
  localparam logic [10:0] TX_SE_MV   [4] = '{11'h262, 11'h1E0, 11'h140, 11'h0F0};
  localparam logic [11:0] RX_NORM_MV [8] = '{12'h1F4, 12'h2BC, 12'h384, 12'h4B0,
                                             12'h578, 12'h640, 12'h708, 12'h7D0};
  localparam logic [11:0] RX_MON_MV  [8] = '{12'h3E8, 12'h578, 12'h708, 12'h898,
                                             12'h898, 12'h898, 12'h898, 12'h898};

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int UPDATE_PERIOD_MS = 1000;
  localparam int UPDATE_CYCLES    = UPDATE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W            = 16;
  localparam int NUM_EVENTS       = 5;

endpackage : lec_pkg

`default_nettype wire

//--- hdl/lec_top.sv
// Purpose: per-channel loss detection, threshold selection and error count control
// Assumes: APB slave with zero wait states; line pins are asynchronous to pclk
// Notes:   pin strobes are edge-detected after a two-flop synchroniser
//
// The implementer's own choices: the APB slave port and the register addresses.
`default_nettype none

// Summary of operation
// (R1) declare tx loss after period of low pulses; clear on any high pulse
// (R2) period field: 00 gives 16, 01 gives 32, 1x gives 64 pulses
// (R3) tx threshold code maps to differential or single-ended peak voltage table
// (R4) line monitor mode uses its own receive threshold table
// (R5) zero-run definition bit selects ANSI when zero, FCC when one
// (R6) violation insert bit inserts one violation at next mark, then self-clears
// (R7) rising error insert bit injects one pattern bit error, then self-clears
// (R8) count select field picks which error events are counted
// (R9) count mode zero means manual update, one means update every second
// (R10) in manual mode a rising update-request bit snapshots the count
// (R11) software writes update-request back to zero before the next request
// (R12) every update restarts accumulation from zero
module lec_top
  import lec_pkg::*;
#(
  parameter int UPD_CYCLES = UPDATE_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line side strobes and levels
  input  wire logic        tx_slot_pin,
  input  wire logic        tx_above_pin,
  input  wire logic        tx_mark_pin,
  input  wire logic        prbs_slot_pin,
  input  wire logic [4:0]  error_event_pins,
  // line side controls
  output logic             tx_loss_flag,
  output logic      [10:0] tx_threshold_mv,
  output logic      [11:0] rx_threshold_mv,
  output logic             zero_run_definition,
  output logic             violation_insert_pulse,
  output logic             error_insert_pulse,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detect
  localparam int NPIN = 9;

  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] prev_q;
  logic [NPIN-1:0] rise;
  logic            slot_rise;
  logic            above;
  logic            mark_rise;
  logic            prbs_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= {error_event_pins, prbs_slot_pin, tx_mark_pin, tx_above_pin, tx_slot_pin};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always_comb begin
    rise      = sync2_q & ~prev_q;
    slot_rise = rise[0];
    above     = sync2_q[1];
    mark_rise = rise[2];
    prbs_rise = rise[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [7:0]  los_q,  los_d;
  logic [7:0]  err_q,  err_d;
  logic [1:0]  line_q, line_d;
  logic [2:0]  ists_q, ists_d;
  logic [2:0]  imsk_q, imsk_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr;
  logic        rd_setup;
  logic        wr_err;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == LOS_CFG_OFF)  || (a == ERR_CTL_OFF) || (a == CNT_HIGH_OFF) ||
                (a == CNT_LOW_OFF)  || (a == INT_STS_OFF) || (a == INT_MSK_OFF)  ||
                (a == LINE_CFG_OFF);
  endfunction : is_mapped

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata  = rdata_q;

  always_comb begin
    wr       = psel && penable && pwrite && is_mapped(paddr);
    rd_setup = psel && !penable && !pwrite;
    wr_err   = wr && (paddr == ERR_CTL_OFF);
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit loss detector
  logic [6:0] quiet_q, quiet_d;
  logic       flag_q,  flag_d;
  logic [6:0] period;

  function automatic logic [6:0] period_len(input logic [1:0] code);
    if (code[1]) begin
      period_len = PERIOD_LONG;                                                 // R2
    end else if (code[0]) begin
      period_len = PERIOD_MID;                                                  // R2
    end else begin
      period_len = PERIOD_SHORT;                                                // R2
    end
  endfunction : period_len

  always_comb begin
    period  = period_len(los_q[TX_PER_LSB +: 2]);
    quiet_d = quiet_q;
    flag_d  = flag_q;
    if (slot_rise) begin
      if (above) begin
        quiet_d = '0;                                                           // R1
        flag_d  = 1'b0;                                                         // R1
      end else if (quiet_q + 7'h01 >= period) begin
        // saturate so a shorter period chosen later still declares at once
        quiet_d = period;
        flag_d  = 1'b1;                                                         // R1
      end else begin
        quiet_d = quiet_q + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= '0;
      flag_q  <= 1'b0;
    end else begin
      quiet_q <= quiet_d;
      flag_q  <= flag_d;
    end
  end

  assign tx_loss_flag = flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // threshold tables
  logic [10:0] txthr_q;
  logic [11:0] rxthr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txthr_q <= TX_DIFF_MV[1];
      rxthr_q <= RX_NORM_MV[1];
    end else begin
      txthr_q <= line_q[SINGLE_END_BIT] ? TX_SE_MV[los_q[TX_THR_LSB +: 2]]
                                        : TX_DIFF_MV[los_q[TX_THR_LSB +: 2]];   // R3
      rxthr_q <= line_q[MONITOR_BIT] ? RX_MON_MV[los_q[RX_THR_LSB +: 3]]
                                     : RX_NORM_MV[los_q[RX_THR_LSB +: 3]];      // R4
    end
  end

  assign tx_threshold_mv = txthr_q;
  assign rx_threshold_mv = rxthr_q;

  ////////////////////////////////////////////////////////////////////////////
  // insertion, registers and interrupts
  lec_cnt_if cif ();

  logic viol_fire;
  logic err_fire;
  logic vpulse_q;
  logic epulse_q;
  logic mreq_q, mreq_d;
  logic [2:0] ev;

  always_comb begin
    viol_fire = err_q[VIOL_INS_BIT] && mark_rise;                               // R6
    err_fire  = err_q[ERR_INS_BIT] && prbs_rise;                                // R7
    // software may only raise the request on a fresh zero-to-one step
    mreq_d    = wr_err && pwdata[CNT_REQ_BIT] && !err_q[CNT_REQ_BIT]
                && !pwdata[CNT_MODE_BIT];                                       // R10 R11
    los_d  = (wr && paddr == LOS_CFG_OFF)  ? pwdata[7:0] : los_q;
    line_d = (wr && paddr == LINE_CFG_OFF) ? pwdata[1:0] : line_q;
    imsk_d = (wr && paddr == INT_MSK_OFF)  ? pwdata[2:0] : imsk_q;
    err_d  = err_q;
    if (viol_fire) begin
      err_d[VIOL_INS_BIT] = 1'b0;                                               // R6
    end
    if (err_fire) begin
      err_d[ERR_INS_BIT] = 1'b0;                                                // R7
    end
    // a fresh write is the newer request, so it wins over the self-clear
    if (wr_err) begin
      err_d = pwdata[7:0];
    end
    ev = '0;
    ev[IRQ_DECLARE_BIT] = flag_d && !flag_q;
    ev[IRQ_CLEAR_BIT]   = !flag_d && flag_q;
    ev[IRQ_UPDATE_BIT]  = cif.updated;
    ists_d = ists_q;
    if (wr && paddr == INT_STS_OFF) begin
      ists_d = ists_q & ~pwdata[2:0];
    end
    ists_d = ists_d | ev;
    rdata_d = rdata_q;
    if (rd_setup) begin
      rdata_d = '0;
      unique case (paddr)
        LOS_CFG_OFF:  rdata_d[7:0] = los_q;
        ERR_CTL_OFF:  rdata_d[7:0] = err_q;
        CNT_HIGH_OFF: rdata_d[7:0] = cif.count[15:8];
        CNT_LOW_OFF:  rdata_d[7:0] = cif.count[7:0];
        INT_STS_OFF:  rdata_d[2:0] = ists_q;
        INT_MSK_OFF:  rdata_d[2:0] = imsk_q;
        LINE_CFG_OFF: rdata_d[1:0] = line_q;
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_q    <= LOS_CFG_RST;
      err_q    <= ERR_CTL_RST;
      line_q   <= LINE_CFG_RST;
      imsk_q   <= INT_MSK_RST;
      ists_q   <= '0;
      rdata_q  <= '0;
      vpulse_q <= 1'b0;
      epulse_q <= 1'b0;
      mreq_q   <= 1'b0;
    end else begin
      los_q    <= los_d;
      err_q    <= err_d;
      line_q   <= line_d;
      imsk_q   <= imsk_d;
      ists_q   <= ists_d;
      rdata_q  <= rdata_d;
      vpulse_q <= viol_fire;
      epulse_q <= err_fire;
      mreq_q   <= mreq_d;
    end
  end

  assign zero_run_definition    = err_q[ZERO_DEF_BIT];                          // R5
  assign violation_insert_pulse = vpulse_q;
  assign error_insert_pulse     = epulse_q;
  assign irq                    = |(ists_q & imsk_q);

  assign cif.sel        = err_q[COUNT_EVENT_SELECT_LSB +: 3];                              // R8
  assign cif.auto_mode  = err_q[CNT_MODE_BIT];                                  // R9
  assign cif.manual_req = mreq_q;
  assign cif.events     = rise[8:4];

  lec_err_counter #(
    .UPD_CYCLES (UPD_CYCLES)
  ) u_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (cif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_loss_declare: assert property ( // R1
    (slot_rise && !above && !flag_q && quiet_q + 7'h01 == period) |=> tx_loss_flag)
    else $error("loss not declared at end of quiet period");
  a_loss_clear: assert property ( // R1
    (slot_rise && above) |=> (!tx_loss_flag && quiet_q == 7'h00))
    else $error("loss not cleared by a pulse above threshold");
  a_period_long: assert property ( // R2
    (los_q[1] && slot_rise && !above && quiet_q == 7'h3E) |=> $stable(tx_loss_flag))
    else $error("long period declared one pulse early");
  a_tx_thresh: assert property ( // R3
    (!$past(line_q[SINGLE_END_BIT]) && $past(los_q[3:2]) == 2'h1) |-> tx_threshold_mv == 11'h384)
    else $error("differential default threshold wrong");
  a_rx_monitor: assert property ( // R4
    ($past(line_q[MONITOR_BIT]) && $past(los_q[6:4]) == 3'h3) |-> rx_threshold_mv == 12'h898)
    else $error("monitor mode threshold wrong");
  a_zero_def: assert property ( // R5
    (wr_err && pwdata[ZERO_DEF_BIT]) |=> zero_run_definition)
    else $error("zero run definition not applied");
  a_viol_once: assert property ( // R6
    (viol_fire && !wr_err) |=> (violation_insert_pulse && !err_q[VIOL_INS_BIT]) ##1 !violation_insert_pulse)
    else $error("violation insert not single and self-clearing");
  a_err_once: assert property ( // R7
    (err_fire && !wr_err) |=> (error_insert_pulse && !err_q[ERR_INS_BIT]))
    else $error("error insert not self-clearing");
  a_manual_gate: assert property ( // R10
    (wr_err && pwdata[CNT_MODE_BIT]) |=> !cif.manual_req)
    else $error("manual request passed in automatic mode");

endmodule : lec_top

`default_nettype wire
